// ==== prs_defs.svh ====
`ifndef PRS_DEFS_SVH
`define PRS_DEFS_SVH

// Word indices of the registers (byte address divided by four)
`define PRS_OFS_CTRL        3'h0
`define PRS_OFS_STATUS      3'h1
`define PRS_OFS_IRQ_STATUS  3'h2
`define PRS_OFS_IRQ_MASK    3'h3

// Control word field positions
`define PRS_CTRL_DET_SEL      0
`define PRS_CTRL_SRC_FIXED    1
`define PRS_CTRL_CONV_EN      2
`define PRS_CTRL_ZERO_LIM     3
`define PRS_CTRL_INRUSH       4
`define PRS_CTRL_CORE_EN      8
`define PRS_CTRL_ANALOG_EN    9
`define PRS_CTRL_MEM_EN       10
`define PRS_CTRL_OFS_CORE     12
`define PRS_CTRL_OFS_ANALOG   14
`define PRS_CTRL_OFS_IO       16

// Status word field positions
`define PRS_ST_ABOVE_IO       0
`define PRS_ST_BUS_VALID      1
`define PRS_ST_BATT_WINS      2
`define PRS_ST_FIVE_PRESENT   3
`define PRS_ST_STEAL          4
`define PRS_ST_BATT_SEL       5

// Interrupt bits
`define PRS_IRQ_INSERT        0
`define PRS_IRQ_REMOVE        1

// Offset codes: -50, -25, 0, +25 mV from the converter target
`define PRS_OFS_M50           2'h0
`define PRS_OFS_M25           2'h1
`define PRS_OFS_ZERO          2'h2
`define PRS_OFS_P25           2'h3

// Reset values
`define PRS_RST_OFS           2'h2
`define PRS_RST_IRQ_MASK      2'h0

// Analog thresholds realised in the comparators themselves
`define PRS_ABOVE_IO_OFFSET_MV 600
`define PRS_BATT_COMPARE_PCT   85
`define PRS_INRUSH_LIMIT_MA    100

// Boot inrush hold time and clock
`define PRS_INRUSH_HOLD_US    10
`define PRS_CLK_MHZ           100

`endif

// ==== prs_pkg.sv ====
package prs_pkg;

  // One bus word
  typedef logic [31:0] prs_word_t;

  // Offset selection code
  typedef logic [1:0] prs_ofs_t;

  // Boot phase of the inrush limiter
  typedef enum logic [0:0] {
    PRS_BOOT_LIMIT = 1'b0,
    PRS_BOOT_RUN   = 1'b1
  } prs_boot_state_t;

endpackage

// ==== prs_sync.sv ====
`timescale 1ns/1ps

module prs_sync #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  // First stage, read only by the second stage
  logic [W-1:0] meta_q;

  // Two flops per comparator line against metastability
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// ==== prs_top.sv ====
// Notes on behaviour
// - Startup uses five-volt-above-I/O detection
// - Above-I/O detect trips near I/O plus 600mV
// - Converter input: automatic or fixed 4.2V rail
// - Automatic picks larger of 4.2V, 85% battery
// - Battery selection feeds full battery voltage
// - 4.2V rail steals charger current past drop-out
// - I/O regulator: five volt present, no zero-limit
// - 1.5V regulator follows only its enable bit
// - Default: core/analog on with 5V, converter off
// - 5V and converter on: own enable bits decide
// - No 5V: core/analog follow own enable bits
// - Regulator offset -50, -25, 0, +25 mV
// - Inrush limit set at boot, self-clears later
// - Zero-limit bit minimises five-volt current
// - Bus-valid insert/remove raise an interrupt
//
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "prs_defs.svh"

module prs_top #(
  parameter int INRUSH_CYCLES =
    `PRS_INRUSH_HOLD_US * `PRS_CLK_MHZ
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [4:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire prs_pkg::prs_word_t avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output prs_pkg::prs_word_t     avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              cmp_five_above_io,
  input  wire logic              cmp_bus_valid,
  input  wire logic              cmp_batt_wins,
  input  wire logic              cmp_dropout,
  output logic                   io_reg_en,
  output logic                   core_reg_en,
  output logic                   analog_reg_en,
  output logic                   mem_reg_en,
  output logic                   converter_en,
  output logic                   converter_from_battery,
  output logic                   charger_throttle,
  output logic                   inrush_limit,
  output logic                   zero_limit,
  output prs_pkg::prs_ofs_t      core_ofs,
  output prs_pkg::prs_ofs_t      analog_ofs,
  output prs_pkg::prs_ofs_t      io_ofs,
  output logic                   irq
);
  import prs_pkg::*;

  // Core/analog enable, shared by both rails
  function automatic logic rail_enable(input logic five,
                                       input logic conv,
                                       input logic en_bit);
    rail_enable = (five & ~conv)           // Default gate
                | (five & conv & en_bit)   // With converter running
                | (~five & en_bit);        // No five-volt supply
  endfunction

  // Byte-lane merge for writes
  function automatic prs_word_t merge(input prs_word_t old,
                                      input prs_word_t wd,
                                      input logic [3:0] be);
    prs_word_t r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[8*i +: 8] = wd[8*i +: 8];
    end
    merge = r;
  endfunction

  localparam int CNT_W = $clog2(INRUSH_CYCLES + 1);

  // Synchronised comparator levels
  logic [3:0]      cmp_s;
  logic            s_above_io;       // Startup detect
  logic            s_bus_valid;      // Accurate detect
  logic            s_batt_wins;      // 85% battery above 4.2V rail
  logic            s_dropout;        // 4.2V rail dropped too far
  // Control fields
  logic            det_sel_q;        // 0: above-I/O, 1: bus-valid
  logic            src_fixed_q;      // 1: converter fixed on 4.2V
  logic            conv_en_q;        // Converter enable bit
  logic            zero_lim_q;       // Zero-current limit bit
  logic [2:0]      reg_en_q;         // Core, analog, 1.5V enables
  prs_ofs_t        ofs_core_q;
  prs_ofs_t        ofs_analog_q;
  prs_ofs_t        ofs_io_q;
  // Boot inrush sequencing
  prs_boot_state_t boot_q;
  logic [CNT_W-1:0] boot_cnt_q;
  // Interrupt state
  logic            bus_valid_prev_q; // For edge detection
  logic [1:0]      irq_stat_q;       // Sticky insert/remove
  logic [1:0]      irq_mask_q;       // 1 lets the bit through
  logic [1:0]      irq_set;
  // Bus decode
  logic            acc;              // Access completes this edge
  logic            wr_acc;
  logic [2:0]      widx;
  logic            mapped;
  logic            five_present;
  prs_word_t       ctrl_word;
  prs_word_t       stat_word;
  prs_word_t       ctrl_new;
  prs_word_t       rd_word;

  // Analog lines cross into this clock through two flops
  prs_sync #(
    .W (4)
  ) u_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in ({cmp_dropout, cmp_batt_wins,
                cmp_bus_valid, cmp_five_above_io}),
    .sync_out (cmp_s)
  );

  assign s_above_io  = cmp_s[0];
  assign s_bus_valid = cmp_s[1];
  assign s_batt_wins = cmp_s[2];
  assign s_dropout   = cmp_s[3];

  // Above-I/O comparator already carries its ~600mV margin
  assign five_present = det_sel_q ? s_bus_valid : s_above_io;

  // A request completes on the edge where waitrequest is low
  assign acc    = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_acc = acc & avs_write;
  assign widx   = avs_address[4:2];
  assign mapped = (avs_address[1:0] == 2'h0);

  // Control word as software sees it
  always_comb
  begin
    ctrl_word = '0;
    ctrl_word[`PRS_CTRL_DET_SEL]   = det_sel_q;
    ctrl_word[`PRS_CTRL_SRC_FIXED] = src_fixed_q;
    ctrl_word[`PRS_CTRL_CONV_EN]   = conv_en_q;
    ctrl_word[`PRS_CTRL_ZERO_LIM]  = zero_lim_q;
    ctrl_word[`PRS_CTRL_INRUSH]    = (boot_q == PRS_BOOT_LIMIT);
    ctrl_word[`PRS_CTRL_MEM_EN:`PRS_CTRL_CORE_EN] = reg_en_q;
    ctrl_word[`PRS_CTRL_OFS_CORE +: 2]   = ofs_core_q;
    ctrl_word[`PRS_CTRL_OFS_ANALOG +: 2] = ofs_analog_q;
    ctrl_word[`PRS_CTRL_OFS_IO +: 2]     = ofs_io_q;
  end

  // Status word
  always_comb
  begin
    stat_word = '0;
    stat_word[`PRS_ST_ABOVE_IO]     = s_above_io;
    stat_word[`PRS_ST_BUS_VALID]    = s_bus_valid;
    stat_word[`PRS_ST_BATT_WINS]    = s_batt_wins;
    stat_word[`PRS_ST_FIVE_PRESENT] = five_present;
    stat_word[`PRS_ST_STEAL]        = charger_throttle;
    stat_word[`PRS_ST_BATT_SEL]     = converter_from_battery;
  end

  assign ctrl_new = merge(ctrl_word, avs_writedata, avs_byteenable);

  // Read multiplexer; unmapped words read as zero
  always_comb
  begin
    rd_word = '0;
    if (mapped)
    begin
      case (widx)
        `PRS_OFS_CTRL:       rd_word = ctrl_word;
        `PRS_OFS_STATUS:     rd_word = stat_word;
        `PRS_OFS_IRQ_STATUS: rd_word = {30'h0, irq_stat_q};
        `PRS_OFS_IRQ_MASK:   rd_word = {30'h0, irq_mask_q};
        default:             rd_word = '0;
      endcase
    end
  end

  // One wait cycle per access, then a one-cycle release
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
    end
    else if (avs_waitrequest && (avs_read || avs_write))
    begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= avs_read ? rd_word : 32'h0000_0000;
    end
    else
    begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Control register; detection starts on the above-I/O method
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      det_sel_q    <= 1'b0;
      src_fixed_q  <= 1'b0;
      conv_en_q    <= 1'b0;
      zero_lim_q   <= 1'b0;
      reg_en_q     <= 3'h0;
      ofs_core_q   <= `PRS_RST_OFS;
      ofs_analog_q <= `PRS_RST_OFS;
      ofs_io_q     <= `PRS_RST_OFS;
    end
    else if (wr_acc && mapped && widx == `PRS_OFS_CTRL)
    begin
      det_sel_q    <= ctrl_new[`PRS_CTRL_DET_SEL];
      src_fixed_q  <= ctrl_new[`PRS_CTRL_SRC_FIXED];
      conv_en_q    <= ctrl_new[`PRS_CTRL_CONV_EN];
      zero_lim_q   <= ctrl_new[`PRS_CTRL_ZERO_LIM];
      reg_en_q     <= ctrl_new[`PRS_CTRL_MEM_EN:`PRS_CTRL_CORE_EN];
      // Any code is legal; -25mV avoids contention
      ofs_core_q   <= ctrl_new[`PRS_CTRL_OFS_CORE +: 2];
      ofs_analog_q <= ctrl_new[`PRS_CTRL_OFS_ANALOG +: 2];
      ofs_io_q     <= ctrl_new[`PRS_CTRL_OFS_IO +: 2];
    end
  end

  // Inrush limit holds from reset, then drops by itself
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      boot_q     <= PRS_BOOT_LIMIT;
      boot_cnt_q <= '0;
    end
    else
    begin
      case (boot_q)
        PRS_BOOT_LIMIT:
        begin
          if (boot_cnt_q == CNT_W'(INRUSH_CYCLES - 1))
            boot_q <= PRS_BOOT_RUN;
          else
            boot_cnt_q <= boot_cnt_q + CNT_W'(1);
        end
        PRS_BOOT_RUN:
          boot_q <= PRS_BOOT_RUN;
        default:
          boot_q <= PRS_BOOT_LIMIT;
      endcase
    end
  end

  // Regulator enables and converter source, all registered
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      io_reg_en              <= 1'b0;
      core_reg_en            <= 1'b0;
      analog_reg_en          <= 1'b0;
      mem_reg_en             <= 1'b0;
      converter_en           <= 1'b0;
      converter_from_battery <= 1'b0;
      charger_throttle       <= 1'b0;
      inrush_limit           <= 1'b1;
      zero_limit             <= 1'b0;
      core_ofs               <= `PRS_RST_OFS;
      analog_ofs             <= `PRS_RST_OFS;
      io_ofs                 <= `PRS_RST_OFS;
    end
    else
    begin
      io_reg_en     <= five_present & ~zero_lim_q;
      core_reg_en   <= rail_enable(five_present, conv_en_q,
                                   reg_en_q[0]);
      analog_reg_en <= rail_enable(five_present, conv_en_q,
                                   reg_en_q[1]);
      mem_reg_en    <= reg_en_q[2];
      converter_en  <= conv_en_q;
      // Battery wins only when 85% of it beats the 4.2V rail;
      // the switch then feeds the full battery voltage
      converter_from_battery <= ~src_fixed_q & s_batt_wins;
      // 4.2V rail keeps priority over the charger
      charger_throttle <= five_present & s_dropout;
      inrush_limit     <= (boot_q == PRS_BOOT_LIMIT);
      zero_limit       <= zero_lim_q;
      core_ofs         <= ofs_core_q;
      analog_ofs       <= ofs_analog_q;
      io_ofs           <= ofs_io_q;
    end
  end

  // Insert and remove edges of the synchronised bus-valid level
  assign irq_set = {bus_valid_prev_q & ~s_bus_valid,
                    ~bus_valid_prev_q & s_bus_valid};

  // Sticky flags; a new event beats a same-cycle clear
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bus_valid_prev_q <= 1'b0;
      irq_stat_q       <= 2'h0;
    end
    else
    begin
      bus_valid_prev_q <= s_bus_valid;
      if (wr_acc && mapped && widx == `PRS_OFS_IRQ_STATUS
          && avs_byteenable[0])
        irq_stat_q <= (irq_stat_q & ~avs_writedata[1:0]) | irq_set;
      else
        irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  // Interrupt mask register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      irq_mask_q <= `PRS_RST_IRQ_MASK;
    else if (wr_acc && mapped && widx == `PRS_OFS_IRQ_MASK
             && avs_byteenable[0])
      irq_mask_q <= avs_writedata[1:0];
  end

  // Level interrupt, one cycle behind the flags
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_q & irq_mask_q);
  end

endmodule

// ==== prs_top_monitor.sv ====
`timescale 1ns/1ps

module prs_top_monitor #(
  parameter int INRUSH_CYCLES = 1000
) (
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic              avs_waitrequest,
  input wire logic              cmp_five_above_io,
  input wire logic              cmp_bus_valid,
  input wire logic              cmp_batt_wins,
  input wire logic              cmp_dropout,
  input wire logic              io_reg_en,
  input wire logic              core_reg_en,
  input wire logic              analog_reg_en,
  input wire logic              mem_reg_en,
  input wire logic              converter_en,
  input wire logic              converter_from_battery,
  input wire logic              charger_throttle,
  input wire logic              inrush_limit,
  input wire logic              zero_limit,
  input wire prs_pkg::prs_ofs_t core_ofs
);
  import prs_pkg::*;

  // Edges since reset release; keeps 3-deep looks out of reset
  int cnt_q;

  // Saturates so a long run never wraps it
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cnt_q <= 0;
    else if (cnt_q < 100000)
      cnt_q <= cnt_q + 1;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_io_needs_five: assert property (
    io_reg_en |-> $past(cmp_five_above_io, 3) || $past(cmp_bus_valid, 3))
    else $error("io regulator on without five volt");
  a_io_zero_off: assert property (io_reg_en |-> !zero_limit)
    else $error("io regulator on under zero limit");
  a_batt_source: assert property (
    converter_from_battery |-> $past(cmp_batt_wins, 3))
    else $error("battery chosen while rail larger");
  a_throttle_cause: assert property (
    !$past(cmp_dropout, 3) |-> !charger_throttle)
    else $error("charger throttled without dropout");
  a_core_default: assert property (
    cnt_q > 3 && $past(cmp_five_above_io, 3) && $past(cmp_bus_valid, 3)
    && !converter_en |-> core_reg_en && analog_reg_en)
    else $error("default regulators off with five volt");
  a_mem_by_write: assert property (
    $changed(mem_reg_en) |-> $past(avs_write, 2) || $past(avs_write, 3))
    else $error("memory regulator moved without a write");
  a_offset_reset: assert property (
    $past(resetn) == 1'h0 |-> core_ofs == 2'h2)
    else $error("offset not at reset code");
  a_inrush_boot: assert property (
    cnt_q < INRUSH_CYCLES + 1 |-> inrush_limit)
    else $error("inrush limit dropped early");
  a_inrush_clear: assert property (
    cnt_q > INRUSH_CYCLES |-> !inrush_limit)
    else $error("inrush limit never cleared");
  a_wait_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");

  // Main scenarios reached
  c_core_with_conv: cover property (core_reg_en && converter_en);
  c_inrush_end: cover property ($fell(inrush_limit));
  c_batt_pick: cover property ($rose(converter_from_battery));
endmodule

bind prs_top prs_top_monitor #(.INRUSH_CYCLES(INRUSH_CYCLES)) mon_i (
  .clk(clk), .resetn(resetn), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .cmp_five_above_io(cmp_five_above_io),
  .cmp_bus_valid(cmp_bus_valid), .cmp_batt_wins(cmp_batt_wins),
  .cmp_dropout(cmp_dropout), .io_reg_en(io_reg_en),
  .core_reg_en(core_reg_en), .analog_reg_en(analog_reg_en),
  .mem_reg_en(mem_reg_en), .converter_en(converter_en),
  .converter_from_battery(converter_from_battery),
  .charger_throttle(charger_throttle), .inrush_limit(inrush_limit),
  .zero_limit(zero_limit), .core_ofs(core_ofs));

// ==== prs_top_test.sv ====
`timescale 1ns/1ps

module prs_top_test;
  import prs_pkg::*;

  // Bench drives every input from time zero
  logic       clk = 1'h0;
  logic       resetn = 1'h0;
  logic [4:0] avs_address = 5'h0;
  logic       avs_read = 1'h0;
  logic       avs_write = 1'h0;
  prs_word_t  avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  prs_word_t  avs_readdata;
  logic       avs_waitrequest;
  logic       cmp_five_above_io = 1'h0;
  logic       cmp_bus_valid = 1'h0;
  logic       cmp_batt_wins = 1'h0;
  logic       cmp_dropout = 1'h0;
  logic       io_reg_en, core_reg_en, analog_reg_en, mem_reg_en;
  logic       converter_en, converter_from_battery, charger_throttle;
  logic       inrush_limit, zero_limit, irq;
  prs_ofs_t   core_ofs, analog_ofs, io_ofs;
  prs_word_t  rd_q;
  int         n_errors = 0;
  int         tests_run = 0;

  // Short boot hold so the limiter ends early in the run
  prs_top #(.INRUSH_CYCLES(30)) prs_top_i (
    .clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cmp_five_above_io(cmp_five_above_io), .cmp_bus_valid(cmp_bus_valid),
    .cmp_batt_wins(cmp_batt_wins), .cmp_dropout(cmp_dropout),
    .io_reg_en(io_reg_en), .core_reg_en(core_reg_en),
    .analog_reg_en(analog_reg_en), .mem_reg_en(mem_reg_en),
    .converter_en(converter_en),
    .converter_from_battery(converter_from_battery),
    .charger_throttle(charger_throttle), .inrush_limit(inrush_limit),
    .zero_limit(zero_limit), .core_ofs(core_ofs), .analog_ofs(analog_ofs),
    .io_ofs(io_ofs), .irq(irq));

  initial
  begin
    forever #5 clk = ~clk;
  end

  task automatic tally_and_finish();
    if (n_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input prs_word_t g, input prs_word_t e);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One access; request held until waitrequest is seen low
  task automatic xfer(input logic w, input logic [4:0] a, input prs_word_t d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'h0);
    rd_q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask

  task automatic rdchk(input logic [4:0] a, input prs_word_t e);
    xfer(1'h0, a, 32'h0);
    chk(rd_q, e);
  endtask

  // Control word plus comparators {dropout,batt,bus,above}, then outputs
  task automatic step(input prs_word_t c, input logic [3:0] m);
    logic f;
    logic fb;
    // Firmware keeps every offset at -25mV (code 1) here
    xfer(1'h1, 5'h0, c | 32'h00015000);
    {cmp_dropout, cmp_batt_wins, cmp_bus_valid, cmp_five_above_io} <= m;
    repeat (5) @(posedge clk);
    f = c[0] ? m[1] : m[0];
    fb = ~c[1] & m[2];
    chk({24'h0, io_reg_en, core_reg_en, analog_reg_en, mem_reg_en,
         converter_en, converter_from_battery, charger_throttle, zero_limit},
        {24'h0, f & ~c[3], (f & ~c[2]) | c[8], (f & ~c[2]) | c[9], c[10],
         c[2], fb, f & m[3], c[3]});
    rdchk(5'h4, {26'h0, fb, f & m[3], f, m[2:0]});
    rdchk(5'h0, c | 32'h00015000);
  endtask

  // Watchdog; run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end

  initial
  begin
    repeat (6) @(posedge clk);
    resetn <= 1'h1;
    chk({31'h0, inrush_limit}, 32'h1);
    rdchk(5'h0, 32'h0002A010);
    repeat (40) @(posedge clk);
    chk({31'h0, inrush_limit}, 32'h0);
    step(32'h0, 4'h1);
    step(32'h1, 4'h1);
    step(32'h1, 4'h2);
    step(32'h1, 4'h3);
    step(32'h5, 4'h2);
    step(32'h105, 4'h2);
    step(32'h201, 4'h0);
    step(32'h409, 4'h2);
    step(32'h0, 4'h4);
    step(32'h2, 4'h4);
    step(32'h0, 4'h9);
    step(32'h0, 4'h8);
    xfer(1'h1, 5'hC, 32'h3);
    xfer(1'h1, 5'h8, 32'h3);
    cmp_bus_valid <= 1'h1;
    repeat (6) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    rdchk(5'h8, 32'h1);
    xfer(1'h1, 5'h8, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    cmp_bus_valid <= 1'h0;
    repeat (6) @(posedge clk);
    rdchk(5'h8, 32'h2);
    chk({31'h0, irq}, 32'h1);
    xfer(1'h1, 5'hC, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    xfer(1'h1, 5'h8, 32'h2);
    rdchk(5'h8, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      xfer(1'h1, 5'h0, {14'h0, k[1:0], k[1:0], k[1:0], 12'h0});
      repeat (3) @(posedge clk);
      chk({26'h0, core_ofs, analog_ofs, io_ofs}, {26'h0, {3{k[1:0]}}});
    end
    rdchk(5'h14, 32'h0);
    rdchk(5'h2, 32'h0);
    xfer(1'h1, 5'h10, 32'hFFFFFFFF);
    rdchk(5'h0, 32'h0003F000);
    // Only lane 2 lands in control; interrupt mask needs lane 0
    avs_byteenable <= 4'h4;
    xfer(1'h1, 5'h0, 32'hFF01FFFF);
    avs_byteenable <= 4'hE;
    xfer(1'h1, 5'hC, 32'h3);
    avs_byteenable <= 4'hF;
    rdchk(5'h0, 32'h0001F000);
    rdchk(5'hC, 32'h0);
    tally_and_finish();
  end
endmodule
